// ### common/hdlc_ctrl_pkg.sv
// Purpose: Shared constants and carriers of the D-channel event and command block
// Assumes: AHB-Lite word access, one register per aligned word
// Notes: Byte address of a register is four times its index
package hdlc_ctrl_pkg;

   // Register indices; byte address is index * 4
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
   localparam logic [7:0] IDX_COMMAND = 8'h21;
   localparam logic [7:0] IDX_LINK_MODE = 8'h22;
   localparam logic [7:0] IDX_EXT_IRQ_STATUS = 8'h24;

   // Reset values
   localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
   localparam logic [7:0] EXT_IRQ_STATUS_RST = 8'h00;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;

   // irq_status bit positions
   localparam int BIT_RX_MSG_END = 7;
   localparam int BIT_RX_POOL_FULL = 6;
   localparam int BIT_PEER_STATUS = 5;
   localparam int BIT_TX_POOL_READY = 4;
   localparam int BIT_TIMER_EXPIRY = 3;
   localparam int BIT_EXT_SUMMARY = 0;

   // extended_irq_status bit positions
   localparam int BIT_TX_REPEAT = 7;
   localparam int BIT_TX_UNDERRUN = 6;
   localparam int BIT_PROTOCOL_ERR = 5;
   localparam int BIT_RX_OVERFLOW = 4;

   // command bit positions, one command per bit
   localparam int CMD_RX_ACK = 7;
   localparam int CMD_RX_RESET = 6;
   localparam int CMD_RX_NOT_READY = 5;
   localparam int CMD_TIMER_START = 4;
   localparam int CMD_TX_TRANSPARENT = 3;
   localparam int CMD_TX_AUTO = 2;
   localparam int CMD_CLOSE_FRAME = 1;
   localparam int CMD_TX_RESET = 0;

   // link_mode bit positions
   localparam int MODE_MANUAL = 0;
   localparam int MODE_RNR_ACTIVE = 1;
   localparam int MODE_RX_WAIT = 2;
   localparam int MODE_TX_BUSY = 3;

   typedef enum logic [1:0] {TX_IDLE, TX_OPEN, TX_CLOSING, TX_WAIT_ACK} tx_state_t;

   // Events from the receive side of the frame engine
   typedef struct packed {
      logic pool_stored;
      logic frame_end;
      logic frame_lost;
      logic bad_nr;
      logic s_with_info;
      logic i_not_command;
      logic s_undefined;
      logic rr_rnr_seen;
      logic i_or_s_seen;
      logic ext_timer_expired;
      logic t200_expired;
      logic n200_expired;
   } rx_evt_t;

   // Events from the transmit side of the frame engine
   typedef struct packed {
      logic space_ready;
      logic fifo_empty;
      logic frame_sent;
      logic tx_error;
      logic peer_nak;
      logic peer_ack;
   } tx_evt_t;

   // One-cycle strobes to the frame engine
   typedef struct packed {
      logic rx_release;
      logic rx_clear;
      logic seq_reset;
      logic send_rnr;
      logic timer_start;
      logic tx_go;
      logic tx_transparent;
      logic tx_close;
      logic tx_abort;
      logic tx_clear;
   } ctrl_t;

endpackage

// ### rtl/hdlc_dchannel_irq_and_command_ctrl.sv
// Purpose: Event flags and command strobes of an HDLC D-channel controller
// Assumes: Frame engine on the same clock; event inputs are one-cycle pulses
// Notes: AHB-Lite slave, zero wait states, always OKAY
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module hdlc_dchannel_irq_and_command_ctrl (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire hdlc_ctrl_pkg::rx_evt_t rx_evt,
   input wire hdlc_ctrl_pkg::tx_evt_t tx_evt,
   output hdlc_ctrl_pkg::ctrl_t ctrl,
   output logic rnr_active
);

   typedef struct packed {
      logic [31:0] rdata;
      logic ready;
      logic resp;
      logic wr_pend;
      logic [7:0] wr_idx;
      logic [7:0] irq_flags;
      logic [7:0] ext_flags;
      logic manual_mode;
      logic rnr;
      logic rnr_out;
      logic rx_wait;
      logic held_v;
      logic held_end;
      hdlc_ctrl_pkg::tx_state_t tx_state;
      logic tx_auto;
      hdlc_ctrl_pkg::ctrl_t ctrl;
   } state_t;

   state_t s_q;
   state_t s_d;

   logic take;
   logic mapped;
   logic [7:0] idx;
   logic [7:0] cmd;
   logic [7:0] set_irq;
   logic [7:0] set_ext;
   logic [7:0] clr_irq;
   logic [7:0] clr_ext;
   logic auto;
   logic rx_evt_any;
   logic tx_send;
   logic tx_fail;
   logic ext_any;

   always_comb begin
      s_d = s_q;
      s_d.ctrl = '0;
      s_d.ready = 1'b1;
      s_d.resp = 1'b0;
      set_irq = 8'h00;
      set_ext = 8'h00;
      clr_irq = 8'h00;
      clr_ext = 8'h00;
      cmd = 8'h00;
      auto = ~s_q.manual_mode;
      ext_any = |s_q.ext_flags;

      // Address phase
      take = hsel & htrans[1] & hready;
      idx = haddr[9:2];
      mapped = (haddr[31:10] == 22'h0);
      if (take) begin
         s_d.wr_pend = hwrite & mapped;
         s_d.wr_idx = idx;
         s_d.rdata = hdlc_ctrl_pkg::RDATA_RST;
         if (!hwrite && mapped) begin
            case (idx)
               hdlc_ctrl_pkg::IDX_IRQ_STATUS: begin
                  s_d.rdata[7:0] = s_q.irq_flags;
                  s_d.rdata[hdlc_ctrl_pkg::BIT_EXT_SUMMARY] = ext_any;
                  clr_irq = 8'hFF;
               end
               hdlc_ctrl_pkg::IDX_EXT_IRQ_STATUS: begin
                  s_d.rdata[7:0] = s_q.ext_flags;
                  clr_ext = 8'hFF;
               end
               hdlc_ctrl_pkg::IDX_LINK_MODE: begin
                  s_d.rdata[hdlc_ctrl_pkg::MODE_MANUAL] = s_q.manual_mode;
                  s_d.rdata[hdlc_ctrl_pkg::MODE_RNR_ACTIVE] = s_q.rnr;
                  s_d.rdata[hdlc_ctrl_pkg::MODE_RX_WAIT] = s_q.rx_wait;
                  s_d.rdata[hdlc_ctrl_pkg::MODE_TX_BUSY] =
                     (s_q.tx_state != hdlc_ctrl_pkg::TX_IDLE);
               end
               default: begin
                  s_d.rdata = hdlc_ctrl_pkg::RDATA_RST;
               end
            endcase
         end
      end else if (hready) begin
         s_d.wr_pend = 1'b0;
      end

      // Data phase of a write
      if (s_q.wr_pend) begin
         case (s_q.wr_idx)
            hdlc_ctrl_pkg::IDX_COMMAND: begin
               cmd = hwdata[7:0];
            end
            hdlc_ctrl_pkg::IDX_LINK_MODE: begin
               s_d.manual_mode = hwdata[hdlc_ctrl_pkg::MODE_MANUAL];
            end
            default: begin
               cmd = 8'h00;
            end
         endcase
      end

      // Receiver-not-ready stays in effect until a command write drops it
      if (s_q.wr_pend && s_q.wr_idx == hdlc_ctrl_pkg::IDX_COMMAND) begin
         s_d.rnr = cmd[hdlc_ctrl_pkg::CMD_RX_NOT_READY];
      end
      s_d.rnr_out = s_d.rnr & ~s_d.manual_mode;
      s_d.ctrl.send_rnr = auto & s_q.rnr & rx_evt.i_or_s_seen;

      // Receive side commands
      s_d.ctrl.rx_release = cmd[hdlc_ctrl_pkg::CMD_RX_ACK];
      s_d.ctrl.rx_clear = cmd[hdlc_ctrl_pkg::CMD_RX_RESET];
      s_d.ctrl.seq_reset = cmd[hdlc_ctrl_pkg::CMD_RX_RESET] & auto;
      s_d.ctrl.timer_start = cmd[hdlc_ctrl_pkg::CMD_TIMER_START];

      // Pool and end events, one reported at a time
      rx_evt_any = rx_evt.pool_stored | rx_evt.frame_end;
      if (cmd[hdlc_ctrl_pkg::CMD_RX_RESET]) begin
         s_d.rx_wait = 1'b0;
         s_d.held_v = 1'b0;
         s_d.held_end = 1'b0;
      end else begin
         if (cmd[hdlc_ctrl_pkg::CMD_RX_ACK] && s_q.rx_wait) begin
            if (s_q.held_v) begin
               // Release the held event now that storage is freed
               s_d.held_v = 1'b0;
               if (s_q.held_end) begin
                  set_irq[hdlc_ctrl_pkg::BIT_RX_MSG_END] = 1'b1;
               end else begin
                  set_irq[hdlc_ctrl_pkg::BIT_RX_POOL_FULL] = 1'b1;
               end
            end else begin
               s_d.rx_wait = 1'b0;
            end
         end
         if (rx_evt_any) begin
            if (s_d.rx_wait) begin
               s_d.held_v = 1'b1;
               s_d.held_end = rx_evt.frame_end;
            end else begin
               s_d.rx_wait = 1'b1;
               if (rx_evt.frame_end) begin
                  set_irq[hdlc_ctrl_pkg::BIT_RX_MSG_END] = 1'b1;
               end else begin
                  set_irq[hdlc_ctrl_pkg::BIT_RX_POOL_FULL] = 1'b1;
               end
            end
         end
      end

      // Receive error and link events
      set_ext[hdlc_ctrl_pkg::BIT_RX_OVERFLOW] = rx_evt.frame_lost;
      set_ext[hdlc_ctrl_pkg::BIT_PROTOCOL_ERR] = auto & (rx_evt.bad_nr |
         rx_evt.s_with_info | rx_evt.i_not_command | rx_evt.s_undefined);
      set_irq[hdlc_ctrl_pkg::BIT_PEER_STATUS] = auto & rx_evt.rr_rnr_seen;
      set_irq[hdlc_ctrl_pkg::BIT_TIMER_EXPIRY] = auto ?
         (rx_evt.t200_expired & rx_evt.n200_expired) : rx_evt.ext_timer_expired;

      // Transmit side
      tx_fail = tx_evt.tx_error | (auto & tx_evt.peer_nak);
      set_ext[hdlc_ctrl_pkg::BIT_TX_REPEAT] = tx_fail;
      tx_send = cmd[hdlc_ctrl_pkg::CMD_TX_TRANSPARENT] | cmd[hdlc_ctrl_pkg::CMD_TX_AUTO];

      if (cmd[hdlc_ctrl_pkg::CMD_TX_RESET]) begin
         // Serializer ends the frame with seven one bits
         s_d.ctrl.tx_abort = (s_q.tx_state != hdlc_ctrl_pkg::TX_IDLE);
         s_d.ctrl.tx_clear = 1'b1;
         s_d.tx_state = hdlc_ctrl_pkg::TX_IDLE;
      end else if (tx_send) begin
         s_d.ctrl.tx_go = 1'b1;
         s_d.ctrl.tx_transparent = cmd[hdlc_ctrl_pkg::CMD_TX_TRANSPARENT];
         s_d.ctrl.tx_close = cmd[hdlc_ctrl_pkg::CMD_CLOSE_FRAME];
         s_d.tx_auto = ~cmd[hdlc_ctrl_pkg::CMD_TX_TRANSPARENT];
         if (cmd[hdlc_ctrl_pkg::CMD_CLOSE_FRAME]) begin
            s_d.tx_state = hdlc_ctrl_pkg::TX_CLOSING;
         end else begin
            s_d.tx_state = hdlc_ctrl_pkg::TX_OPEN;
         end
      end else begin
         case (s_q.tx_state)
            hdlc_ctrl_pkg::TX_IDLE: begin
               s_d.tx_state = hdlc_ctrl_pkg::TX_IDLE;
            end
            hdlc_ctrl_pkg::TX_OPEN: begin
               if (cmd[hdlc_ctrl_pkg::CMD_CLOSE_FRAME]) begin
                  s_d.ctrl.tx_close = 1'b1;
                  s_d.tx_state = hdlc_ctrl_pkg::TX_CLOSING;
               end else if (tx_evt.fifo_empty) begin
                  s_d.ctrl.tx_abort = 1'b1;
                  set_ext[hdlc_ctrl_pkg::BIT_TX_UNDERRUN] = 1'b1;
                  s_d.tx_state = hdlc_ctrl_pkg::TX_IDLE;
               end else if (tx_fail) begin
                  s_d.tx_state = hdlc_ctrl_pkg::TX_IDLE;
               end else if (tx_evt.space_ready) begin
                  set_irq[hdlc_ctrl_pkg::BIT_TX_POOL_READY] = 1'b1;
               end
            end
            hdlc_ctrl_pkg::TX_CLOSING: begin
               if (tx_fail) begin
                  s_d.tx_state = hdlc_ctrl_pkg::TX_IDLE;
               end else if (tx_evt.frame_sent) begin
                  if (s_q.tx_auto && auto) begin
                     s_d.tx_state = hdlc_ctrl_pkg::TX_WAIT_ACK;
                  end else begin
                     set_irq[hdlc_ctrl_pkg::BIT_TX_POOL_READY] = 1'b1;
                     s_d.tx_state = hdlc_ctrl_pkg::TX_IDLE;
                  end
               end
            end
            hdlc_ctrl_pkg::TX_WAIT_ACK: begin
               if (tx_fail) begin
                  s_d.tx_state = hdlc_ctrl_pkg::TX_IDLE;
               end else if (tx_evt.peer_ack) begin
                  set_irq[hdlc_ctrl_pkg::BIT_TX_POOL_READY] = 1'b1;
                  s_d.tx_state = hdlc_ctrl_pkg::TX_IDLE;
               end
            end
            default: begin
               s_d.tx_state = hdlc_ctrl_pkg::TX_IDLE;
            end
         endcase
      end

      // Sticky flags: a set in the clearing cycle survives
      s_d.irq_flags = (s_q.irq_flags & ~clr_irq) | set_irq;
      s_d.irq_flags[hdlc_ctrl_pkg::BIT_EXT_SUMMARY] = 1'b0;
      s_d.ext_flags = (s_q.ext_flags & ~clr_ext) | set_ext;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         s_q.rdata <= hdlc_ctrl_pkg::RDATA_RST;
         s_q.ready <= 1'b1;
         s_q.resp <= 1'b0;
         s_q.wr_pend <= 1'b0;
         s_q.wr_idx <= 8'h00;
         s_q.irq_flags <= hdlc_ctrl_pkg::IRQ_STATUS_RST;
         s_q.ext_flags <= hdlc_ctrl_pkg::EXT_IRQ_STATUS_RST;
         s_q.manual_mode <= 1'b0;
         s_q.rnr <= 1'b0;
         s_q.rnr_out <= 1'b0;
         s_q.rx_wait <= 1'b0;
         s_q.held_v <= 1'b0;
         s_q.held_end <= 1'b0;
         s_q.tx_state <= hdlc_ctrl_pkg::TX_IDLE;
         s_q.tx_auto <= 1'b0;
         s_q.ctrl <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign hrdata = s_q.rdata;
   assign hreadyout = s_q.ready;
   assign hresp = s_q.resp;
   assign ctrl = s_q.ctrl;
   assign rnr_active = s_q.rnr_out;

endmodule // hdlc_dchannel_irq_and_command_ctrl

// ### test/hdlc_ctrl_sva.sv
// Purpose: Port-level checks of the event and command block
// Assumes: Zero-wait AHB-Lite slave, command decoded in its data phase
// Notes: Bound to every instance of the block
`timescale 1ns/1ns
module hdlc_ctrl_sva (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire hdlc_ctrl_pkg::rx_evt_t rx_evt,
   input wire hdlc_ctrl_pkg::ctrl_t ctrl,
   input wire logic rnr_active
);
   logic cmd_q;
   wire logic ack_cmd = cmd_q && hwdata[7];
   wire logic clr_cmd = cmd_q && hwdata[6];
   wire logic tim_cmd = cmd_q && hwdata[4];
   wire logic cls_cmd = cmd_q && hwdata[1];
   wire logic txr_cmd = cmd_q && hwdata[0];
   wire logic isn_seen = rx_evt.i_or_s_seen;
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cmd_q <= 1'b0;
      end else begin
         cmd_q <= hsel && htrans[1] && hready && hwrite && haddr == 32'h0000_0084;
      end
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);
   ack_release_a: assert property (ack_cmd |=> ctrl.rx_release)
      else $error("acknowledge gave no release strobe");
   rx_clear_a: assert property (clr_cmd |=> ctrl.rx_clear)
      else $error("receiver reset gave no clear strobe");
   tx_clear_a: assert property (txr_cmd |=> ctrl.tx_clear)
      else $error("transmitter reset gave no clear strobe");
   timer_start_a: assert property (tim_cmd |=> ctrl.timer_start)
      else $error("timer start gave no strobe");
   release_src_a: assert property (ctrl.rx_release |-> $past(ack_cmd))
      else $error("release strobe without acknowledge");
   close_src_a: assert property (ctrl.tx_close |-> $past(cls_cmd))
      else $error("close strobe without close bit");
   rnr_answer_a: assert property (ctrl.send_rnr == ($past(isn_seen) && $past(rnr_active)))
      else $error("not-ready answer mismatch");
   go_qual_a: assert property (ctrl.tx_transparent |-> ctrl.tx_go)
      else $error("transparent qualifier without send");
endmodule // hdlc_ctrl_sva
bind hdlc_dchannel_irq_and_command_ctrl hdlc_ctrl_sva u_sva (.clock(clock), .arst_n(arst_n),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hready(hready), .rx_evt(rx_evt), .ctrl(ctrl), .rnr_active(rnr_active));

// ### test/frame_engine_model.sv
// Purpose: Behavioural frame engine facing the block
// Assumes: Bench requests events one cycle ahead
// Notes: Reports a sent frame a fixed time after a close strobe, unless a clear strobe comes in between
`timescale 1ns/1ns
module frame_engine_model #(parameter int SEND_DLY = 3) (
   input wire logic clock,
   input wire logic arst_n,
   input wire hdlc_ctrl_pkg::rx_evt_t rx_req,
   input wire hdlc_ctrl_pkg::tx_evt_t tx_req,
   input wire hdlc_ctrl_pkg::ctrl_t ctrl,
   output hdlc_ctrl_pkg::rx_evt_t rx_evt,
   output hdlc_ctrl_pkg::tx_evt_t tx_evt
);
   int cnt;
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rx_evt <= '0;
         tx_evt <= '0;
         cnt <= 0;
      end else begin
         rx_evt <= rx_req;
         tx_evt <= tx_req;
         if (ctrl.tx_clear) begin
            cnt <= 0;
         end else if (ctrl.tx_close) begin
            cnt <= SEND_DLY;
         end else if (cnt > 0) begin
            cnt <= cnt - 1;
         end
         if (cnt == 1) begin
            tx_evt.frame_sent <= 1'b1;
         end
      end
   end
endmodule // frame_engine_model

// ### test/hdlc_dchannel_irq_and_command_ctrl_tb_top.sv
// Purpose: Self-checking bench of the event and command block
// Assumes: Flags read back clear-on-read; zero-wait bus
// Notes: Rows fire events, write, then compare strobes and one register
`timescale 1ns/1ns
module hdlc_dchannel_irq_and_command_ctrl_tb_top;
   typedef struct packed {
      logic [11:0] rx;
      logic [5:0] tx;
      logic [7:0] wa;
      logic [7:0] wd;
      logic [9:0] ec;
      logic [7:0] ra;
      logic [7:0] ed;
   } row_t;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic rnr_active;
   logic clr = 1'b0;
   logic [31:0] rd;
   hdlc_ctrl_pkg::rx_evt_t rx_req = '0;
   hdlc_ctrl_pkg::rx_evt_t rx_evt;
   hdlc_ctrl_pkg::tx_evt_t tx_req = '0;
   hdlc_ctrl_pkg::tx_evt_t tx_evt;
   hdlc_ctrl_pkg::ctrl_t ctrl;
   hdlc_ctrl_pkg::ctrl_t seen;
   int fail_count = 0;
   int checks_done = 0;
   row_t rows [0:29] = '{
      '{12'h000,6'h00,8'h00,8'h00,10'h000,8'h80,8'h00},
      '{12'h000,6'h00,8'h00,8'h00,10'h000,8'hFC,8'h00},
      '{12'h800,6'h00,8'h00,8'h00,10'h000,8'h80,8'h40},
      '{12'h400,6'h00,8'h00,8'h00,10'h000,8'h80,8'h00},
      '{12'h000,6'h00,8'h84,8'h80,10'h200,8'h80,8'h80},
      '{12'h000,6'h00,8'h84,8'h80,10'h200,8'h80,8'h00},
      '{12'h800,6'h00,8'h00,8'h00,10'h000,8'h80,8'h40},
      '{12'h400,6'h00,8'h84,8'h40,10'h180,8'h80,8'h00},
      '{12'h800,6'h00,8'h00,8'h00,10'h000,8'h80,8'h40},
      '{12'h200,6'h00,8'h00,8'h00,10'h000,8'h80,8'h01},
      '{12'h000,6'h00,8'h00,8'h00,10'h000,8'h90,8'h10},
      '{12'h100,6'h00,8'h00,8'h00,10'h000,8'h90,8'h20},
      '{12'h080,6'h00,8'h00,8'h00,10'h000,8'h90,8'h20},
      '{12'h040,6'h00,8'h00,8'h00,10'h000,8'h90,8'h20},
      '{12'h020,6'h00,8'h00,8'h00,10'h000,8'h90,8'h20},
      '{12'h010,6'h00,8'h00,8'h00,10'h000,8'h80,8'h20},
      '{12'h004,6'h00,8'h88,8'h01,10'h000,8'h80,8'h00},
      '{12'h114,6'h00,8'h88,8'h00,10'h000,8'h80,8'h08},
      '{12'h003,6'h00,8'h00,8'h00,10'h000,8'h80,8'h08},
      '{12'h000,6'h20,8'h00,8'h00,10'h000,8'h80,8'h00},
      '{12'h000,6'h04,8'h00,8'h00,10'h000,8'h90,8'h80},
      '{12'h000,6'h00,8'h84,8'h08,10'h018,8'h80,8'h00},
      '{12'h000,6'h20,8'h84,8'h04,10'h010,8'h80,8'h10},
      '{12'h000,6'h00,8'h84,8'h01,10'h003,8'h80,8'h00},
      '{12'h000,6'h00,8'h84,8'h0A,10'h01C,8'h80,8'h10},
      '{12'h000,6'h00,8'h84,8'h06,10'h014,8'h80,8'h00},
      '{12'h000,6'h01,8'h00,8'h00,10'h000,8'h80,8'h10},
      '{12'h000,6'h10,8'h84,8'h08,10'h01A,8'h90,8'h40},
      '{12'h000,6'h00,8'h84,8'h20,10'h000,8'h80,8'h00},
      '{12'h008,6'h00,8'h00,8'h00,10'h040,8'h80,8'h00}};
   always #4 clock = ~clock;
   always @(posedge clock) seen <= clr ? '0 : (seen | ctrl);
   hdlc_dchannel_irq_and_command_ctrl u_dut (.clock(clock), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .rx_evt(rx_evt), .tx_evt(tx_evt), .ctrl(ctrl), .rnr_active(rnr_active));
   frame_engine_model #(.SEND_DLY(5)) u_peer (.clock(clock), .arst_n(arst_n),
      .rx_req(rx_req), .tx_req(tx_req), .ctrl(ctrl), .rx_evt(rx_evt), .tx_evt(tx_evt));
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_ctrl(input hdlc_ctrl_pkg::ctrl_t exp);
      check("ctrl strobes", 32'(exp), 32'(seen));
   endtask
   // Entered just after a rising edge; returns at the data-phase edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [7:0] d,
         output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h00_0000, d};
      @(posedge clock);
      while (hreadyout !== 1'b1) @(posedge clock);
      q = hrdata;
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      foreach (rows[i]) begin
         clr <= 1'b1;
         rx_req <= rows[i].rx;
         tx_req <= rows[i].tx;
         @(posedge clock);
         clr <= 1'b0;
         rx_req <= '0;
         tx_req <= rows[i].tx & 6'h10;
         @(posedge clock);
         if (rows[i].wa != 8'h00) ahb(1'b1, rows[i].wa, rows[i].wd, rd);
         repeat (10) @(posedge clock);
         tx_req <= '0;
         check_ctrl(rows[i].ec);
         ahb(1'b0, rows[i].ra, 8'h00, rd);
         check("register read", {24'h00_0000, rows[i].ed}, rd);
      end
      @(posedge clock);
      check("not-ready level", 32'h0000_0001, {31'h0, rnr_active});
      ahb(1'b0, 8'h88, 8'h00, rd);
      check("link mode", 32'h0000_0006, rd);
      check("bus response", 32'h0000_0000, {31'h0, hresp});
      rx_req <= 12'h210;
      @(posedge clock);
      rx_req <= '0;
      repeat (2) @(posedge clock);
      arst_n <= 1'b0;
      repeat (2) @(posedge clock);
      check("not-ready in reset", 32'h0000_0000, {31'h0, rnr_active});
      arst_n <= 1'b1;
      @(posedge clock);
      ahb(1'b0, 8'h80, 8'h00, rd);
      check("status after reset", 32'h0000_0000, rd);
      ahb(1'b0, 8'h90, 8'h00, rd);
      check("extended after reset", 32'h0000_0000, rd);
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge clock);
      fail_count++;
      tally_and_finish;
   end
endmodule // hdlc_dchannel_irq_and_command_ctrl_tb_top
